// ===== testbench/lcd_driver_i2c_slave_receiver_test.sv
`timescale 1ns/100ps
module lcd_driver_i2c_slave_receiver_test;
  import ldr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic address_select_strap_i = 1'b0;
  logic [2:0] sub_strap = 3'h0; // hardware subaddress straps
  logic ptr_load_i = 1'b0;
  logic [5:0] ptr_i = 6'h00;
  logic sub_load_i = 1'b0;
  logic [2:0] sub_i = 3'h0;
  logic wr_ready_i = 1'b0;
  logic op_valid_i = 1'b0;
  ldr_op_t op_code_i = OP_NONE;
  logic [7:0] op_data_i = 8'h00;
  logic cmd_valid_o, wr_valid_o, selected_o, op_ready_o, done_o, nack_o, busy_o;
  logic [7:0] cmd_data_o;
  logic [7:0] wr_data_o;
  logic [5:0] wr_addr_o;
  logic byte_op = 1'b0; // the op in flight is a byte
  logic [13:0] wr_q[$]; // notes of expected results
  logic [13:0] cmd_q[$];
  logic [13:0] nack_q[$];
  int failures = 0;
  int checks_done = 0;
  int seed = 32'h3e76;
  ldr_i2c_if ldr_i2c_if_i ();
  ldr_master ldr_master_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus(ldr_i2c_if_i),
    .op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .op_code_i(op_code_i), .op_data_i(op_data_i),
    .done_o(done_o), .nack_o(nack_o), .busy_o(busy_o));
  ldr_slave ldr_slave_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus(ldr_i2c_if_i),
    .address_select_strap_i(address_select_strap_i), .subaddr_strap_bit0_i(sub_strap[0]),
    .subaddr_strap_bit1_i(sub_strap[1]), .subaddr_strap_bit2_i(sub_strap[2]),
    .ptr_load_i(ptr_load_i), .ptr_i(ptr_i), .sub_load_i(sub_load_i), .sub_i(sub_i),
    .cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .selected_o(selected_o));
  ldr_chk ldr_chk_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl(ldr_i2c_if_i.scl),
    .sda(ldr_i2c_if_i.sda), .m_sda_oe(ldr_i2c_if_i.m_sda_oe), .s_sda_o(ldr_i2c_if_i.s_sda_o),
    .s_sda_oe(ldr_i2c_if_i.s_sda_oe));
  // free-running clock
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // random stalls on the write side, so the buffer has to hold bytes
  always @(negedge ref_clk_i) begin
    wr_ready_i <= 1'($random(seed));
  end
  task automatic compare(input string what, input logic [13:0] seen, input logic [13:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // an empty queue gives a value no output can match
  function automatic logic [13:0] pop(ref logic [13:0] q[$]);
    return (q.size() > 0) ? q.pop_front() : 14'h3fff;
  endfunction
  // oldest note against each result as it appears
  always @(posedge ref_clk_i) begin
    if (cmd_valid_o === 1'b1) compare("cmd", 14'(cmd_data_o), pop(cmd_q));
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) compare("write", {wr_addr_o, wr_data_o}, pop(wr_q));
    if (done_o === 1'b1 && byte_op) compare("nack", 14'(nack_o), pop(nack_q));
  end
  // one request, held until taken, then a bounded wait for done
  task automatic op(input ldr_op_t code, input logic [7:0] data, input logic exp_nack);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    op_valid_i = 1'b1;
    op_code_i = code;
    op_data_i = data;
    byte_op = (code == OP_BYTE);
    if (code == OP_BYTE) nack_q.push_back(14'(exp_nack));
    while (op_ready_o !== 1'b1 && n < 1000) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    op_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 7000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 7000) begin
      compare("done", 14'h0, 14'h1);
      results();
    end
  endtask
  task automatic cmd(input logic more);
    logic [7:0] c;
    c = {more, 7'($random(seed))};
    cmd_q.push_back(14'(c));
    op(OP_BYTE, c, 1'b0);
  endtask
  initial begin
    logic [7:0] d;
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    // subaddress 1, pointer one short of the ram end
    sub_strap = 3'h1;
    ptr_i = RAM_LAST - 6'h01;
    ptr_load_i = 1'b1;
    sub_load_i = 1'b1;
    @(negedge ref_clk_i);
    ptr_load_i = 1'b0;
    sub_load_i = 1'b0;
    // an empty request only answers with done and leaves the bus alone
    op(OP_NONE, 8'h00, 1'b0);
    compare("busy", 14'(busy_o), 14'h0);
    op(OP_START, 8'h00, 1'b0);
    compare("busy", 14'(busy_o), 14'h1);
    op(OP_BYTE, {ADDR_FIXED, 2'b00}, 1'b0);
    compare("selected", 14'(selected_o), 14'h1);
    cmd(1'b1);
    cmd(1'b0);
    // two bytes for subaddress 0, then the wrap hands over to this device
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      if (i >= 2) wr_q.push_back({6'(i - 2), d});
      op(OP_BYTE, d, i < 2);
    end
    op(OP_STOP, 8'h00, 1'b0);
    compare("busy", 14'(busy_o), 14'h0);
    // strap mismatch: whole transfer ignored
    op(OP_START, 8'h00, 1'b0);
    op(OP_BYTE, {ADDR_FIXED, 2'b10}, 1'b1);
    compare("selected", 14'(selected_o), 14'h0);
    op(OP_BYTE, 8'h00, 1'b1);
    op(OP_STOP, 8'h00, 1'b0);
    // read refused, repeated start, then strap high accepted
    address_select_strap_i = 1'b1;
    op(OP_START, 8'h00, 1'b0);
    op(OP_BYTE, {ADDR_FIXED, 2'b11}, 1'b1);
    op(OP_START, 8'h00, 1'b0);
    op(OP_BYTE, {ADDR_FIXED, 2'b10}, 1'b0);
    cmd(1'b0);
    op(OP_STOP, 8'h00, 1'b0);
    repeat (200) @(negedge ref_clk_i);
    compare("left", 14'(wr_q.size() + cmd_q.size() + nack_q.size()), 14'h0);
    results();
  end
endmodule

// ===== testbench/ldr_chk.sv
`timescale 1ns/100ps
// watches the shared lines; both ends are design code
module ldr_chk
  import ldr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  localparam int ACK_MIN = 4 * QUARTER_CYC - 4; // one bit period, small slack for sync lag
  localparam int ACK_MAX = 4 * QUARTER_CYC + 4;
  logic scl_d_reg; // line levels one clock back
  logic sda_d_reg;
  logic [3:0] rise_reg; // scl rises in this byte, wraps after the ack clock
  logic [9:0] ack_len_reg; // clocks the ack has been held
  logic idle_reg; // after stop, before start
  wire start_w = scl && scl_d_reg && sda_d_reg && !sda;
  wire stop_w = scl && scl_d_reg && !sda_d_reg && sda;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // delayed levels; reset to idle high so no false edge at release
  always_ff @(posedge ref_clk_i) begin
    scl_d_reg <= sys_rst_i | scl;
    sda_d_reg <= sys_rst_i | sda;
  end
  // bit count restarts at every start, so a repeated start realigns it
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || start_w) begin
      rise_reg <= 4'h0;
    end else if (scl && !scl_d_reg) begin
      rise_reg <= (rise_reg == 4'h8) ? 4'h0 : rise_reg + 4'h1;
    end
  end
  // length of the current ack
  always_ff @(posedge ref_clk_i) begin
    ack_len_reg <= (s_sda_oe && !sys_rst_i) ? ack_len_reg + 10'h1 : 10'h0;
  end
  // bus idle between stop and start
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || stop_w) begin
      idle_reg <= 1'b1;
    end else if (start_w) begin
      idle_reg <= 1'b0;
    end
  end
  // the slave only ever pulls during the ack slot: after the eighth rise, or after the ninth until the next rise
  chk_slave_zero: assert property (s_sda_o == 1'b0 && (!s_sda_oe || rise_reg == 4'h8 || rise_reg == 4'h0))
    else $error("slave pulled sda outside an ack");
  chk_ack_slot: assert property ($rose(s_sda_oe) |-> !scl && rise_reg == 4'h8)
    else $error("ack outside its slot");
  chk_ack_hold: assert property (scl && $past(scl) |-> !$fell(s_sda_oe))
    else $error("ack released while scl high");
  chk_ack_width: assert property ($fell(s_sda_oe) |-> ack_len_reg >= ACK_MIN && ack_len_reg <= ACK_MAX)
    else $error("ack width wrong");
  chk_idle_quiet: assert property (idle_reg |-> !s_sda_oe) else $error("slave active on idle bus");
  chk_start_clocks: assert property (start_w |-> ##[1:600] !scl) else $error("no clock after start");
  chk_stop_idle: assert property (stop_w |=> (scl && sda) [*8]) else $error("bus busy after stop");
  chk_data_stable: assert property ($changed(m_sda_oe) && scl |-> rise_reg <= 4'h1)
    else $error("data changed while scl high");
  chk_idle_start: assert property ($rose(m_sda_oe) && idle_reg |-> scl)
    else $error("idle bus left without start");
  cov_ack: cover property ($rose(s_sda_oe));
  cov_restart: cover property (start_w && !idle_reg);
  cov_stop: cover property (stop_w);
endmodule

// ===== verilog/ldr_i2c_if.sv
`timescale 1ns/100ps
// open-drain two-wire bus; levels resolved here from the enables
interface ldr_i2c_if;
  logic scl; // resolved clock line
  logic sda; // resolved data line
  logic m_scl_o; // master clock output value, always low
  logic m_scl_oe; // master pulls scl
  logic m_sda_o; // master data output value, always low
  logic m_sda_oe; // master pulls sda
  logic s_sda_o; // slave data output value, always low
  logic s_sda_oe; // slave pulls sda
  // pull-ups win unless someone pulls low
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ===== verilog/ldr_master.sv
`timescale 1ns/100ps
// bus master end: one start, byte or stop per request
module ldr_master (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  ldr_i2c_if.master bus,
  input wire logic op_valid_i,
  output logic op_ready_o,
  input wire ldr_pkg::ldr_op_t op_code_i,
  input wire logic [7:0] op_data_i,
  output logic done_o,
  output logic nack_o,
  output logic busy_o
);
  import ldr_pkg::*;

  logic [1:0] s1_reg; // first stage, read only by the second
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] filt_reg; // accepted scl, sda
  ldr_host_state_t state_reg;
  logic [1:0] ph_reg; // quarter within a bit slot
  logic [7:0] q_reg; // cycles within a quarter
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg; // data then a released ack bit
  logic active_reg; // between start and stop, scl kept low
  logic done_reg;
  logic nack_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic scl_next;
  logic sda_next;
  logic tick;
  logic accept;

  // three-stage synchroniser on the bus lines
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        s1_reg[i] <= 1'b1;
        s2_reg[i] <= 1'b1;
        s3_reg[i] <= 1'b1;
        filt_reg[i] <= 1'b1;
      end else begin
        s1_reg[i] <= i ? bus.sda : bus.scl;
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // a fresh start waits for both lines high
  assign op_ready_o = (state_reg == HS_IDLE) &&
                      !(op_code_i == OP_START && !active_reg && !(filt_reg[0] && filt_reg[1]));
  assign accept = op_valid_i && op_ready_o;
  assign tick = (state_reg != HS_IDLE) && (q_reg == QUARTER_LAST);

  // quarter-period divider
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || accept || tick) begin
      q_reg <= 8'h00;
    end else if (state_reg != HS_IDLE) begin
      q_reg <= q_reg + 8'h01;
    end
  end

  // sequencer: four quarters per start, bit or stop
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= HS_IDLE;
      ph_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h1ff;
      active_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (accept) begin
        ph_reg <= 2'h0;
        bit_cnt_reg <= 4'h0;
        shift_reg <= {op_data_i, 1'b1};
        case (op_code_i)
          OP_START: state_reg <= HS_START;
          OP_BYTE: state_reg <= HS_BIT;
          OP_STOP: state_reg <= HS_STOP;
          default: done_reg <= 1'b1;
        endcase
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
        // ack sampled mid-way through the high phase
        if (state_reg == HS_BIT && ph_reg == 2'h1 && bit_cnt_reg == BYTE_BITS) begin
          nack_reg <= filt_reg[1];
        end
        if (ph_reg == 2'h3) begin
          case (state_reg)
            HS_START: begin
              state_reg <= HS_IDLE;
              active_reg <= 1'b1;
              done_reg <= 1'b1;
            end
            HS_BIT: begin
              shift_reg <= {shift_reg[7:0], 1'b1};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == BYTE_BITS) begin
                state_reg <= HS_IDLE;
                done_reg <= 1'b1;
              end
            end
            HS_STOP: begin
              state_reg <= HS_IDLE;
              active_reg <= 1'b0;
              done_reg <= 1'b1;
            end
            default: state_reg <= HS_IDLE;
          endcase
        end
      end
    end
  end

  // line pulls per quarter; sda moves while scl is low, except for start and stop
  always_comb begin
    case (state_reg)
      HS_IDLE: begin
        scl_next = active_reg;
        sda_next = 1'b0;
      end
      HS_START: begin
        scl_next = (ph_reg == 2'h0) ? active_reg : (ph_reg == 2'h3);
        sda_next = ph_reg[1];
      end
      HS_BIT: begin
        scl_next = (ph_reg == 2'h0) || (ph_reg == 2'h3);
        sda_next = !shift_reg[8];
      end
      HS_STOP: begin
        scl_next = (ph_reg == 2'h0);
        sda_next = !ph_reg[1];
      end
      default: begin
        scl_next = 1'b0;
        sda_next = 1'b0;
      end
    endcase
  end

  // registered pin drive
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      scl_oe_reg <= scl_next;
      sda_oe_reg <= sda_next;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_reg;
  assign done_o = done_reg;
  assign nack_o = nack_reg;
  assign busy_o = active_reg;
endmodule

// ===== verilog/ldr_pkg.sv
// How it works
// - sda change while scl high is control
// - master starts only on idle bus
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - eight bits plus ack, unbounded bytes
// - addressed device acks every byte; a full write buffer here withholds the data ack
// - ack holds sda low through scl high
// - slave never drives data, only acks
// - selection uses address, commands, subaddress straps
// - address 011100, strap bit, write bit
// - read requests get no ack
// - strap mismatch ignores until next start
// - command msb clear ends command chain
// - all selected devices ack command bytes
// - data stored at pointer, pointer advances
// - only matching subaddress acks data bytes
// - master ends with stop or restart
// - overflow passes to next device, unacked
// - subaddress straps fixed during access
package ldr_pkg;
  // bus timing: one scl period and the local clock period
  localparam int SCL_PERIOD_NS = 2500;
  localparam int CLK_PERIOD_NS = 5;
  // a quarter scl period is a least time, so round up
  localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
  // fixed upper six bits of the slave address byte
  localparam logic [5:0] ADDR_FIXED = 6'h1c;
  // bit count at which a byte is complete
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // last display ram address of one device
  localparam logic [5:0] RAM_LAST = 6'h27;
  // reset values
  localparam logic [5:0] PTR_RST = 6'h00;
  localparam logic [2:0] SUB_RST = 3'h0;
  localparam logic [5:0] FILT_RST = 6'h03; // scl and sda idle high
  // write buffer shape
  localparam int FIFO_W = 14;
  localparam int FIFO_DEPTH = 32;
  // slave receiver states
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_CMD = 3'b010,
    DS_DATA = 3'b011,
    DS_IGNORE = 3'b100
  } ldr_dev_state_t;
  // master states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BIT = 2'b10,
    HS_STOP = 2'b11
  } ldr_host_state_t;
  // master operations
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_BYTE = 2'b01,
    OP_STOP = 2'b10,
    OP_NONE = 2'b11
  } ldr_op_t;
endpackage

// ===== verilog/ldr_slave.sv
`timescale 1ns/100ps
// write buffer between the receiver and the display ram port
module ldr_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage words
  logic [AW:0] wr_reg; // write pointer with wrap bit
  logic [AW:0] rd_reg; // read pointer with wrap bit
  logic full;
  logic empty;
  // full when pointers differ only in the wrap bit
  assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_reg[AW-1:0]];
  // storage write, no reset needed for data
  always_ff @(posedge ref_clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end
  // pointer update
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

// slave receiver end: address match, command chain, data routing
module ldr_slave (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  ldr_i2c_if.slave bus,
  input wire logic address_select_strap_i,
  input wire logic subaddr_strap_bit0_i,
  input wire logic subaddr_strap_bit1_i,
  input wire logic subaddr_strap_bit2_i,
  input wire logic ptr_load_i,
  input wire logic [5:0] ptr_i,
  input wire logic sub_load_i,
  input wire logic [2:0] sub_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_data_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [5:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic selected_o
);
  import ldr_pkg::*;

  // matches the full address byte: fixed bits, strap bit, write only
  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    addr_match = (b[7:2] == ADDR_FIXED) && (b[1] == sel) && !b[0];
  endfunction

  logic [5:0] raw; // pins: scl, sda, select strap, subaddress straps
  logic [5:0] s1_reg; // first stage, read only by the second
  logic [5:0] s2_reg;
  logic [5:0] s3_reg;
  logic [5:0] filt_reg; // accepted levels
  logic scl_prev_reg;
  logic sda_prev_reg;
  ldr_dev_state_t state_reg;
  logic [3:0] bit_cnt_reg; // bits of the current byte
  logic [7:0] shift_reg; // received bits, msb first
  logic ack_phase_reg; // inside the ninth clock
  logic sda_oe_reg; // pulling sda for an ack
  logic [5:0] ptr_reg; // data pointer
  logic [2:0] sub_reg; // subaddress counter
  logic cmd_valid_reg;
  logic [7:0] cmd_data_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_end, ack_end, sub_hit, want_ack, fifo_ready, push;
  logic [FIFO_W-1:0] fifo_out;

  assign raw = {subaddr_strap_bit2_i, subaddr_strap_bit1_i, subaddr_strap_bit0_i,
                address_select_strap_i, bus.sda, bus.scl};

  // three-stage synchroniser; a level is accepted once stages two and three agree
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        s1_reg[i] <= FILT_RST[i];
        s2_reg[i] <= FILT_RST[i];
        s3_reg[i] <= FILT_RST[i];
        filt_reg[i] <= FILT_RST[i];
      end else begin
        s1_reg[i] <= raw[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // previous accepted levels for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= filt_reg[0];
      sda_prev_reg <= filt_reg[1];
    end
  end

  // an sda edge with scl held high is never data
  assign start_det = scl_prev_reg && filt_reg[0] && sda_prev_reg && !filt_reg[1];
  assign stop_det = scl_prev_reg && filt_reg[0] && !sda_prev_reg && filt_reg[1];
  assign scl_rise = filt_reg[0] && !scl_prev_reg;
  assign scl_fall = !filt_reg[0] && scl_prev_reg;
  assign byte_end = scl_fall && (bit_cnt_reg == BYTE_BITS) && !ack_phase_reg;
  assign ack_end = scl_fall && ack_phase_reg;
  // straps must not move during an access, so they are read directly
  assign sub_hit = (sub_reg == filt_reg[5:3]);
  assign push = byte_end && (state_reg == DS_DATA) && sub_hit;

  // ack decision for the byte just received
  always_comb begin
    case (state_reg)
      DS_ADDR: want_ack = addr_match(shift_reg, filt_reg[2]);
      DS_CMD: want_ack = 1'b1;
      DS_DATA: want_ack = sub_hit && fifo_ready;
      default: want_ack = 1'b0;
    endcase
  end

  // protocol state; start and stop win over byte handling
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= DS_IDLE;
    end else if (start_det) begin
      state_reg <= DS_ADDR;
    end else if (stop_det) begin
      state_reg <= DS_IDLE;
    end else if (byte_end) begin
      case (state_reg)
        DS_ADDR: state_reg <= want_ack ? DS_CMD : DS_IGNORE;
        DS_CMD: begin
          if (!shift_reg[7]) begin
            state_reg <= DS_DATA;
          end
        end
        default: state_reg <= state_reg;
      endcase
    end
  end

  // bit counter and shifter; sample on the rising scl edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (ack_end) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && bit_cnt_reg != BYTE_BITS &&
                 (state_reg == DS_ADDR || state_reg == DS_CMD || state_reg == DS_DATA)) begin
      shift_reg <= {shift_reg[6:0], filt_reg[1]};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // ack driver: pull from the eighth falling edge to the ninth
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_phase_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_phase_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (byte_end) begin
      ack_phase_reg <= 1'b1;
      sda_oe_reg <= want_ack;
    end else if (ack_end) begin
      ack_phase_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
  end

  // data pointer and subaddress counter; every device advances in step
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ptr_reg <= PTR_RST;
      sub_reg <= SUB_RST;
    end else begin
      if (ptr_load_i) begin
        ptr_reg <= ptr_i;
      end else if (byte_end && state_reg == DS_DATA) begin
        ptr_reg <= (ptr_reg == RAM_LAST) ? PTR_RST : ptr_reg + 6'h01;
      end
      if (sub_load_i) begin
        sub_reg <= sub_i;
      end else if (byte_end && state_reg == DS_DATA && ptr_reg == RAM_LAST) begin
        sub_reg <= sub_reg + 3'h1;
      end
    end
  end

  // command bytes go out to the decoder, one pulse each
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cmd_valid_reg <= 1'b0;
      cmd_data_reg <= 8'h00;
    end else begin
      cmd_valid_reg <= byte_end && (state_reg == DS_CMD);
      if (byte_end && state_reg == DS_CMD) begin
        cmd_data_reg <= shift_reg;
      end
    end
  end

  // a full buffer refuses the byte, which also withholds the ack
  ldr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i({ptr_reg, shift_reg}),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_out)
  );

  assign wr_addr_o = fifo_out[13:8];
  assign wr_data_o = fifo_out[7:0];
  assign cmd_valid_o = cmd_valid_reg;
  assign cmd_data_o = cmd_data_reg;
  assign selected_o = (state_reg == DS_CMD) || (state_reg == DS_DATA);
  // only ever pulls low for acks, never sends data
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_reg;
endmodule
